//--- core/pms_defs.vh
// Contract
// - RAM preservation: oscillator off, timekeeper clocks system
// - Clock request low forces internal oscillator
// - LCD sleep: regulator low, logic gated off
// - Refuse sleep while wake pending, hold interrupt
// - Sleep until wake event, then reset-complete interrupt
// - Pins held in sleep, reset on wake
// - Bypass bit selects external clock pin
// - Timekeeping sleep also disables the display
`ifndef PMS_DEFS_VH
`define PMS_DEFS_VH

// ===================================================
// Register codes seen by the sequencer
`define PMS_OSC_SYNC      8'h07
`define PMS_OSC_PIN_CTRL  8'h03
`define PMS_OSC_KEEP_ON   8'h06
`define PMS_CLKSEL_RTC    8'h05
`define PMS_CLKSEL_IOSC1  8'h00

// ===================================================
// Bit positions
`define PMS_ULP_DISPLAY_BIT  3
`define PMS_ULP_MATCH_BIT    1
`define PMS_MISC_BYPASS_BIT  7
`define PMS_MISC_OVR_BIT     2

// ===================================================
// Mode codes (one-hot)
`define PMS_MODE_W        4
`define PMS_MODE_NORMAL   4'h1
`define PMS_MODE_RAMPRES  4'h2
`define PMS_MODE_ULP_LCD  4'h4
`define PMS_MODE_ULP_TK   4'h8

// ===================================================
// Wake event indices
`define PMS_WAKE_W      3
`define PMS_WAKE_NONE   3'h0

`endif

//--- core/pms_wake_latch.v
`timescale 1ns/1ps
// ===================================================
// Sticky wake-event collector; set wins over clear
module pms_wake_latch
#(
  parameter WIDTH = 3
)
(
  // Clock and reset
  input  wire             clk_sys,
  input  wire             reset,
  // Events and clear
  input  wire [WIDTH-1:0] event_in,
  input  wire             clear,
  // Pending flags
  output reg  [WIDTH-1:0] pending_reg
);

  genvar gi;

  // ===================================================
  // One sticky flop per event source
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_flag
      always @(posedge clk_sys or posedge reset)
      begin
        if (reset)
          pending_reg[gi] <= 1'b0;
        else if (event_in[gi])
          pending_reg[gi] <= 1'b1;   // Set beats clear
        else if (clear)
          pending_reg[gi] <= 1'b0;
      end
    end
  endgenerate

endmodule

//--- core/pms_power_mode_sequencer.v
`timescale 1ns/1ps
`include "pms_defs.vh"
// ===================================================
// Power-mode sequencer: normal, RAM preservation, two ULTRA_LOW_POWER modes
module pms_power_mode_sequencer
(
  // Clock and reset
  input  wire        clk_sys,
  input  wire        reset,
  // Host control pins (synchronous)
  input  wire        power_request_n,   // Power request or chip select
  input  wire        clock_request_n,   // Clock request pin
  input  wire        ext_clk_pin,       // ~32 kHz clock on clock pin
  // Register values from the register block
  input  wire [7:0]  internal_osc_control,
  input  wire        internal_osc_wr,   // Write strobe of osc control
  input  wire [7:0]  system_clock_select,
  input  wire [7:0]  misc_control,
  input  wire [7:0]  ultra_low_power_control,
  // Timekeeper inputs
  input  wire        rtc_osc_clk,       // Real-time oscillator output
  input  wire        rtc_running,
  // Wake events: alarm, osc fail, port match
  input  wire [2:0]  wake_event,
  input  wire        wake_ack,          // Host cleared wake flags
  // Mode and power controls
  output reg  [3:0]  mode_reg,
  output reg         iosc_enable_reg,
  output reg         sysclk_from_rtc_reg,
  output reg         regulator_low_reg,
  output reg         logic_power_off_reg,
  output reg         display_enable_reg,
  output reg         port_hold_reg,
  output reg         port_reset_reg,    // Pins to inputs with pull-ups
  output reg         timekeeper_clk_reg,
  output reg         reset_complete_reg,
  output reg         int_pin_n_reg,     // Host interrupt pin, active low
  output reg         refused_reg        // Last entry attempt refused
);

  // ===================================================
  // Local state
  reg  [3:0] mode_next;
  reg        pwr_d_reg;        // Previous power request level
  reg        osc_pin_ctrl_reg; // Oscillator handed to clock pin
  wire [2:0] pending;
  wire       any_pending;
  wire       pwr_rise;
  wire       pwr_fall;
  wire       ulp_request;
  wire       wake_now;
  reg        wake_clear;

  // ===================================================
  // Mode codes; one-hot so each mode is a single flop
  localparam [`PMS_MODE_W-1:0] MODE_NORMAL  = `PMS_MODE_NORMAL;
  localparam [`PMS_MODE_W-1:0] MODE_RAMPRES = `PMS_MODE_RAMPRES;
  localparam [`PMS_MODE_W-1:0] MODE_ULP_LCD = `PMS_MODE_ULP_LCD;
  localparam [`PMS_MODE_W-1:0] MODE_ULP_TK  = `PMS_MODE_ULP_TK;

  // ===================================================
  // Either sleep mode; shared by power outputs and wake logic
  function is_sleep;
    input [`PMS_MODE_W-1:0] mode;
    begin
      is_sleep = (mode == MODE_ULP_LCD) || (mode == MODE_ULP_TK);
    end
  endfunction

  assign pwr_rise    = power_request_n & ~pwr_d_reg;
  assign pwr_fall    = ~power_request_n & pwr_d_reg;
  assign any_pending = |pending | |wake_event;
  assign wake_now    = |wake_event;
  // ULTRA_LOW_POWER entry is asked for when display keep or match enable is set
  assign ulp_request = ultra_low_power_control[`PMS_ULP_DISPLAY_BIT] |
                       ultra_low_power_control[`PMS_ULP_MATCH_BIT];

  // ===================================================
  // Wake flags, kept until the host clears them
  pms_wake_latch #(.WIDTH(`PMS_WAKE_W)) u_wake
  (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .event_in    (wake_event),
    .clear       (wake_clear),
    .pending_reg (pending)
  );

  // ===================================================
  // Edge history of power request
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      pwr_d_reg <= 1'b1;
    else
      pwr_d_reg <= power_request_n;
  end

  // ===================================================
  // Oscillator control: pin control code arms RAM preservation
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      osc_pin_ctrl_reg <= 1'b0;
    else if (internal_osc_wr)
    begin
      // Keep-on or sync code returns control to registers
      osc_pin_ctrl_reg <= (internal_osc_control == `PMS_OSC_PIN_CTRL);
    end
  end

  // ===================================================
  // Mode transitions
  always @*
  begin
    mode_next  = mode_reg;
    wake_clear = 1'b0;
    case (mode_reg)
      MODE_NORMAL:
      begin
        if (pwr_rise && ulp_request)
        begin
          // Pending wake keeps device awake
          if (!any_pending)
          begin
            if (ultra_low_power_control[`PMS_ULP_DISPLAY_BIT])
              mode_next = MODE_ULP_LCD;
            else
              mode_next = MODE_ULP_TK;
          end
        end
        // Slow clock only with override clear and timekeeper running
        else if (clock_request_n && osc_pin_ctrl_reg &&
                 system_clock_select == `PMS_CLKSEL_RTC &&
                 !misc_control[`PMS_MISC_OVR_BIT] && rtc_running)
          mode_next = MODE_RAMPRES;
        if (wake_ack)
          wake_clear = 1'b1;
      end
      MODE_RAMPRES:
      begin
        // Clock request low falls back to internal oscillator
        if (!clock_request_n)
          mode_next = MODE_NORMAL;
        if (wake_ack)
          wake_clear = 1'b1;
      end
      MODE_ULP_LCD, MODE_ULP_TK:
      begin
        // Stay asleep until wake event or host wake
        if (wake_now || pwr_fall)
          mode_next = MODE_NORMAL;
      end
      // Illegal code: recover to the fully awake mode
      default:
        mode_next = MODE_NORMAL;
    endcase
  end

  // ===================================================
  // Mode register and power outputs
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      mode_reg            <= MODE_NORMAL;
      iosc_enable_reg     <= 1'b1;
      sysclk_from_rtc_reg <= 1'b0;
      regulator_low_reg   <= 1'b0;
      logic_power_off_reg <= 1'b0;
      display_enable_reg  <= 1'b1;
      port_hold_reg       <= 1'b0;
      port_reset_reg      <= 1'b0;
      reset_complete_reg  <= 1'b0;
      refused_reg         <= 1'b0;
    end
    else
    begin
      mode_reg            <= mode_next;
      // Internal oscillator runs only in normal mode
      iosc_enable_reg     <= (mode_next == MODE_NORMAL);
      sysclk_from_rtc_reg <= (mode_next == MODE_RAMPRES);
      regulator_low_reg   <= is_sleep(mode_next);
      logic_power_off_reg <= is_sleep(mode_next);
      // Display stays lit except in timekeeping sleep
      display_enable_reg  <= (mode_next != MODE_ULP_TK);
      port_hold_reg       <= is_sleep(mode_next);
      // One-cycle pin reset on leaving ULTRA_LOW_POWER
      port_reset_reg      <= is_sleep(mode_reg) &&
                             (mode_next == MODE_NORMAL);
      // Reset-complete raised on wake, dropped on host ack
      if (is_sleep(mode_reg) && (mode_next == MODE_NORMAL))
        reset_complete_reg <= 1'b1;
      else if (wake_ack)
        reset_complete_reg <= 1'b0;
      // Refusal remembered until the next attempt
      if ((mode_reg == MODE_NORMAL) && pwr_rise && ulp_request)
        refused_reg <= any_pending;
    end
  end

  // ===================================================
  // Interrupt pin: low while wake pending or reset complete
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      int_pin_n_reg <= 1'b1;
    else
      int_pin_n_reg <= ~(|pending | reset_complete_reg);
  end

  // ===================================================
  // Timekeeper clock mux; retimed, so the 32 kHz input
  // must be far slower than clk_sys
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      timekeeper_clk_reg <= 1'b0;
    else if (misc_control[`PMS_MISC_BYPASS_BIT])
      timekeeper_clk_reg <= ext_clk_pin;
    else
      timekeeper_clk_reg <= rtc_osc_clk;
  end

endmodule

//--- dv/pms_host_model.sv
`timescale 1ns/1ps
// ==========
// Host model: drives the power pins and register values
module pms_host_model
(
  // Clock
  input  wire       clk_sys,
  // Pins and register values
  output reg        power_request_n         = 1'b1,
  output reg        clock_request_n         = 1'b1,
  output reg  [7:0] internal_osc_control    = 8'h00,
  output reg        internal_osc_wr         = 1'b0,
  output reg  [7:0] system_clock_select     = 8'h00,
  output reg  [7:0] misc_control            = 8'h00,
  output reg  [7:0] ultra_low_power_control = 8'h00
);
  // Host-side settings that never reach the sequencer
  reg [15:0] irq_enable_pair        = 16'hffff;
  reg [7:0]  bandgap_config         = 8'h00;
  reg [7:0]  timekeeper_osc_control = 8'h01;
  reg        ports_analog           = 1'b0;
  // Move just past the next rising edge
  task step;
    @(posedge clk_sys);
    #2;
  endtask
  // One oscillator control write, strobe for one cycle
  task osc_write(input [7:0] v);
    step;
    internal_osc_control = v;
    internal_osc_wr = 1'b1;
    step;
    internal_osc_wr = 1'b0;
  endtask
  // Sleep request: prepare, pin low, keep bits, pin high
  task ulp_enter(input [7:0] ctrl);
    step;
    ports_analog = 1'b1;
    irq_enable_pair = 16'h1900;
    bandgap_config = ctrl[3] ? 8'hc0 : 8'h80;
    step;
    power_request_n = 1'b0;
    step;
    // Keep bits go in only once the preparation is in place
    if (ports_analog && irq_enable_pair == 16'h1900 && bandgap_config[7])
      ultra_low_power_control = ctrl;
    step;
    power_request_n = 1'b1;
  endtask
  // Wake by pulling the pin low and leaving it there
  task wake_pin;
    step;
    power_request_n = 1'b0;
  endtask
  // Slow-clock entry: clock pin low, sync, pin control, select
  task ram_enter;
    step;
    clock_request_n = 1'b0;
    osc_write(8'h07);
    osc_write(8'h03);
    system_clock_select = 8'h05;
    step;
    clock_request_n = 1'b1;
  endtask
  // Return: clock pin low, then keep oscillator on
  task ram_exit;
    step;
    clock_request_n = 1'b0;
    osc_write(8'h06);
  endtask
  // Bypass hands timekeeping to the clock pin; oscillator stopped
  task set_bypass(input on);
    step;
    misc_control = {on, 7'h00};
    timekeeper_osc_control = on ? 8'h00 : 8'h01;
  endtask
endmodule

//--- dv/pms_props.sv
`timescale 1ns/1ps
// ==========
// Checker on the sequencer ports
module pms_props
(
  // Clock and reset
  input wire       clk_sys,
  input wire       reset,
  // Inputs watched
  input wire       power_request_n,
  input wire       clock_request_n,
  input wire       ext_clk_pin,
  input wire       rtc_osc_clk,
  input wire [7:0] misc_control,
  input wire [7:0] ultra_low_power_control,
  input wire [2:0] wake_event,
  // Outputs watched
  input wire [3:0] mode_reg,
  input wire       iosc_enable_reg,
  input wire       sysclk_from_rtc_reg,
  input wire       regulator_low_reg,
  input wire       logic_power_off_reg,
  input wire       display_enable_reg,
  input wire       port_hold_reg,
  input wire       port_reset_reg,
  input wire       timekeeper_clk_reg,
  input wire       reset_complete_reg,
  input wire       int_pin_n_reg,
  input wire       refused_reg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Mode helpers
  wire asleep = mode_reg[2] | mode_reg[3];
  wire normal = (mode_reg == 4'h1);
  // Quiet request with LCD keep bit must be taken
  a_lcd_entry:
    assert property (normal && $rose(power_request_n) && ultra_low_power_control[3]
      && wake_event == 3'h0 && $past(wake_event) == 3'h0 && int_pin_n_reg
      |=> mode_reg == 4'h4) else $error("lcd sleep entry missed");
  // Event during request: stay awake, flag, interrupt
  a_refuse_busy:
    assert property (normal && $rose(power_request_n) && wake_event != 3'h0
      && (ultra_low_power_control[3] | ultra_low_power_control[1])
      |=> normal && refused_reg ##1 !int_pin_n_reg) else $error("sleep not refused");
  a_lcd_power:
    assert property (mode_reg == 4'h4 |-> regulator_low_reg && logic_power_off_reg
      && display_enable_reg && port_hold_reg) else $error("lcd sleep power wrong");
  a_tk_display:
    assert property (mode_reg == 4'h8 |-> !display_enable_reg && regulator_low_reg)
      else $error("display on in timekeeping sleep");
  a_event_wake:
    assert property (asleep && wake_event != 3'h0 |=> normal && port_reset_reg
      && reset_complete_reg ##1 !port_reset_reg && !int_pin_n_reg) else $error("bad wake");
  a_host_wake:
    assert property (asleep && $fell(power_request_n) && wake_event == 3'h0
      |=> normal && reset_complete_reg ##[1:2] !int_pin_n_reg) else $error("bad pin wake");
  a_stay_asleep:
    assert property (asleep && wake_event == 3'h0 && power_request_n |=> $stable(mode_reg))
      else $error("left sleep without cause");
  a_ram_exit:
    assert property (mode_reg == 4'h2 && !clock_request_n |=> normal && iosc_enable_reg
      && !sysclk_from_rtc_reg) else $error("clock request ignored");
  a_ram_clock:
    assert property (mode_reg == 4'h2 |-> !iosc_enable_reg && sysclk_from_rtc_reg)
      else $error("slow clock mode wrong");
  // Retimer is one flop deep; the check still has the inputs stand five cycles
  a_clk_bypass:
    assert property ((misc_control[7] && ext_clk_pin && !rtc_osc_clk)[*5]
      |-> timekeeper_clk_reg) else $error("bypass clock not used");
  c_lcd: cover property (mode_reg == 4'h4);
  c_tk: cover property (mode_reg == 4'h8);
  c_refused: cover property ($rose(refused_reg));
endmodule
bind pms_power_mode_sequencer pms_props u_props (.*);

//--- dv/testbench.sv
`timescale 1ns/1ps
// ==========
// Self-checking bench for the power-mode sequencer
module testbench;
  // Stimulus and observed nets, joined by name
  logic       clk_sys, reset, ext_clk_pin, rtc_osc_clk, wake_ack;
  logic [2:0] wake_event;
  logic       rtc_running;
  wire        power_request_n, clock_request_n, internal_osc_wr;
  wire  [7:0] internal_osc_control, system_clock_select, misc_control, ultra_low_power_control;
  wire  [3:0] mode_reg;
  wire        iosc_enable_reg, sysclk_from_rtc_reg, regulator_low_reg, logic_power_off_reg;
  wire        display_enable_reg, port_hold_reg, port_reset_reg, timekeeper_clk_reg;
  wire        reset_complete_reg, int_pin_n_reg, refused_reg;
  int         num_errors = 0;
  int         compares = 0;
  pms_power_mode_sequencer u_pms_power_mode_sequencer (.*);
  pms_host_model u_host (.*);
  // 40 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task step;
    @(posedge clk_sys);
    #2;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results;
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Bounded wait for mode and interrupt pin; a hang ends the run
  task wait_st(input [4:0] e);
    int n;
    n = 0;
    while ({mode_reg, int_pin_n_reg} !== e && n < 20)
    begin
      step;
      n++;
    end
    chk({3'h0, mode_reg, int_pin_n_reg}, {3'h0, e});
    if ({mode_reg, int_pin_n_reg} !== e)
      results;
  endtask
  // Host clears the wake flags; pin must release
  task ack;
    step;
    wake_ack = 1'b1;
    step;
    wake_ack = 1'b0;
    wait_st(5'h03);
  endtask
  // ==========
  // Main sequence
  initial
  begin
    reset = 1'b1;
    ext_clk_pin = 1'b0;
    rtc_osc_clk = 1'b0;
    rtc_running = 1'b1;
    wake_event = 3'h0;
    wake_ack = 1'b0;
    repeat (5) @(posedge clk_sys);
    #2;
    reset = 1'b0;
    chk({mode_reg, iosc_enable_reg, display_enable_reg, int_pin_n_reg, refused_reg}, 8'h1e);
    // Each wake source ends an LCD sleep
    for (int i = 0; i < 3; i++)
    begin
      u_host.ulp_enter(8'h08);
      wait_st(5'h09);
      chk({regulator_low_reg, logic_power_off_reg}, 8'h03);
      chk({display_enable_reg, port_hold_reg}, 8'h03);
      repeat (3) step;
      chk({mode_reg, int_pin_n_reg}, 8'h09);
      wake_event = 3'h1 << i;
      step;
      wake_event = 3'h0;
      chk({mode_reg, reset_complete_reg}, 8'h03);
      chk({port_reset_reg, port_hold_reg}, 8'h02);
      wait_st(5'h02);
      ack;
    end
    // Timekeeping sleep, woken by the host pin
    u_host.ulp_enter(8'h02);
    wait_st(5'h11);
    chk({display_enable_reg, regulator_low_reg}, 8'h01);
    u_host.wake_pin;
    wait_st(5'h02);
    chk(reset_complete_reg, 8'h01);
    ack;
    // Request while an event is live is refused
    wake_event = 3'h4;
    u_host.ulp_enter(8'h08);
    step;
    wake_event = 3'h0;
    repeat (2) step;
    chk({mode_reg, refused_reg, int_pin_n_reg}, 8'h06);
    ack;
    // Slow-clock entry waits for a running timekeeper
    rtc_running = 1'b0;
    u_host.ram_enter;
    repeat (3) step;
    chk(mode_reg, 8'h01);
    rtc_running = 1'b1;
    wait_st(5'h05);
    chk({iosc_enable_reg, sysclk_from_rtc_reg}, 8'h01);
    u_host.ram_exit;
    wait_st(5'h03);
    chk({iosc_enable_reg, sysclk_from_rtc_reg}, 8'h02);
    // Timekeeper source follows the bypass bit
    u_host.set_bypass(1'b1);
    ext_clk_pin = 1'b1;
    repeat (6) step;
    chk(timekeeper_clk_reg, 8'h01);
    ext_clk_pin = 1'b0;
    rtc_osc_clk = 1'b1;
    repeat (6) step;
    chk(timekeeper_clk_reg, 8'h00);
    u_host.set_bypass(1'b0);
    repeat (6) step;
    chk(timekeeper_clk_reg, 8'h01);
    results;
  end
endmodule
